// ### include/dxw_pkg.sv
package dxw_pkg;

    // Register bus geometry and offsets.
    localparam int DXW_AW = 8;
    localparam logic [DXW_AW-1:0] DXW_OFS_BASE = 8'ha8;
    localparam logic [DXW_AW-1:0] DXW_OFS_SETUP = 8'hac;
    localparam logic [DXW_AW-1:0] DXW_OFS_CAP = 8'hb0;

    // Translated base field.
    localparam int DXW_BASE_LSB = 6;
    localparam logic [31:0] DXW_BASE_RST = 32'h0000_0000;

    // Window 1 setup field positions.
    localparam int DXW_SETUP_TYPE_BIT = 0;
    localparam int DXW_SETUP_ATYPE_LSB = 1;
    localparam int DXW_SETUP_ATYPE_MSB = 2;
    localparam int DXW_SETUP_PREF_BIT = 3;
    localparam int DXW_MASK_LSB = 6;
    localparam int DXW_MASK_MSB = 30;
    localparam int DXW_SETUP_EN_BIT = 31;
    localparam logic [31:0] DXW_SETUP_RST = 32'h0000_0000;
    localparam logic [31:0] DXW_SETUP_KEEP = 32'hffff_ffce;

    // Address type codes.
    localparam logic [1:0] DXW_ATYPE_32 = 2'h0;
    localparam logic [1:0] DXW_ATYPE_64 = 2'h1;

    // Capability header contents.
    localparam logic [7:0] DXW_CAP_ID = 8'h10;
    localparam logic [7:0] DXW_CAP_NEXT = 8'hf0;
    localparam logic [3:0] DXW_CAP_VER = 4'h1;
    localparam logic [4:0] DXW_CAP_MSGNUM = 5'h00;
    localparam logic [1:0] DXW_CAP_RSVD = 2'h0;

    // Strap capture delay in cycles after reset release.
    localparam logic [1:0] DXW_STRAP_WAIT = 2'h3;

    // Device or port type codes.
    typedef enum logic [3:0] {
        DXW_PT_ENDPOINT = 4'h0,
        DXW_PT_LEGACY_EP = 4'h1,
        DXW_PT_ROOT_PORT = 4'h4,
        DXW_PT_SW_UP = 4'h5,
        DXW_PT_SW_DOWN = 4'h6,
        DXW_PT_EXP_TO_PCI = 4'h7,
        DXW_PT_PCI_TO_EXP = 4'h8
    } dxw_port_type_type;

endpackage

// ### hw/dxw_xlate.sv
module dxw_xlate (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // Window programming.
    input wire logic win_en,
    input wire logic [31:0] win_base,
    input wire logic [31:0] win_mask,
    // Downstream request.
    input wire logic in_valid,
    input wire logic in_hit,
    input wire logic [31:0] in_addr,
    // Translated request.
    output logic out_valid,
    output logic out_translated,
    output logic [31:0] out_addr
);
    import dxw_pkg::*;

    typedef struct packed {
        logic valid;
        logic xl;
        logic [31:0] addr;
    } dxw_xl_state_type;

    dxw_xl_state_type q;
    dxw_xl_state_type d;

    always_comb begin
        d = q;
        if (ce) begin
            d.valid = in_valid;
            d.xl = 1'b0;
            if (in_valid) begin
                // Only the size-mask bits take the base; the offset inside the window passes.
                if (in_hit && win_en) begin
                    d.addr = (in_addr & ~win_mask) | (win_base & win_mask);
                    d.xl = 1'b1;
                end else begin
                    d.addr = in_addr;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out_valid = q.valid;
    assign out_translated = q.xl;
    assign out_addr = q.addr;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    AST_XLATE_HIT: assert property (ce && in_valid && in_hit && win_en |=>
        out_translated && out_addr == (($past(in_addr) & ~$past(win_mask)) | ($past(win_base) & $past(win_mask))))
        else $error("translated address does not merge base and offset");
    AST_XLATE_OFF: assert property (ce && in_valid && !win_en |=>
        !out_translated && out_addr == $past(in_addr))
        else $error("disabled window changed an address");

    COV_XLATE_HIT: cover property (ce && in_valid && in_hit && win_en ##1 out_translated);

endmodule

// ### hw/dxw_regs.sv
// Behaviour
// - Translated base bits 31:6 are software writable, bits 5:0 read zero.
// - Which base bits take part in translation comes from the setup register.
// - Setup bit 0 always reads zero, meaning memory space.
// - Setup bits 2:1 give address type, 00 32-bit, 01 64-bit, reset 00.
// - Size-mask zero makes the base bit read-only; one makes it writable.
// - Setup bit 31 enables window 1; reset value zero.
// - Capability header bits 7:0 read the fixed identifier 10h.
// - Capability header bits 15:8 read F0h, pointing to vital product data.
// - Device type field uses the defined codes; 0111 and 1000 are bridges.
// - Device type reads 7h in forward mode and 8h in reverse mode.
// - Slot implemented bit 24 reads 0 forward and 1 reverse.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
module dxw_regs (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,

    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [dxw_pkg::DXW_AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,

    // Bridge direction strap pin, high for reverse operation.
    input wire logic reverse_strap,

    // Side loading of the setup register.
    input wire logic side_load_valid,
    input wire logic [31:0] side_load_data,

    // Downstream request to translate.
    input wire logic dn_valid,
    input wire logic dn_hit,
    input wire logic [31:0] dn_addr,

    // Translated request.
    output logic xl_valid,
    output logic xl_translated,
    output logic [31:0] xl_addr,

    // Status.
    output logic win_enable,
    output logic reverse_mode
);
    import dxw_pkg::*;

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic [1:0] strap_cnt;
        logic reverse;
        logic ready;
        logic wr_pend;
        logic [DXW_AW-1:0] wr_addr;
        logic [31:0] rdata;
        logic [31:0] base;
        logic [31:0] setup;
    } dxw_reg_state_type;

    dxw_reg_state_type q;
    dxw_reg_state_type d;

    logic addr_phase;
    logic [31:0] wmask;

    // Bit 31 of the base has no size-mask bit, so it is always part of the window.
    function automatic logic [31:0] dxw_wmask(input logic [31:0] setup);
        dxw_wmask = {1'b1, setup[DXW_MASK_MSB:DXW_MASK_LSB], 6'h00};
    endfunction

    function automatic dxw_port_type_type dxw_port_type(input logic rev);
        // Forward runs as an express-to-conventional bridge.
        if (rev) begin
            dxw_port_type = DXW_PT_PCI_TO_EXP;
        end else begin
            dxw_port_type = DXW_PT_EXP_TO_PCI;
        end
    endfunction

    function automatic logic dxw_port_type_known(input logic [3:0] code);
        // Every code outside the enumeration is reserved.
        case (code)
            DXW_PT_ENDPOINT, DXW_PT_LEGACY_EP, DXW_PT_ROOT_PORT, DXW_PT_SW_UP,
            DXW_PT_SW_DOWN, DXW_PT_EXP_TO_PCI, DXW_PT_PCI_TO_EXP: dxw_port_type_known = 1'b1;
            default: dxw_port_type_known = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] dxw_cap_word(input logic rev);
        dxw_port_type_type pt;
        pt = dxw_port_type(rev);
        // Identifier and next link are fixed.
        // The slot flag follows the direction.
        dxw_cap_word = {DXW_CAP_RSVD, DXW_CAP_MSGNUM, rev, pt, DXW_CAP_VER, DXW_CAP_NEXT, DXW_CAP_ID};
    endfunction

    function automatic logic [31:0] dxw_read(
        input logic [DXW_AW-1:0] addr,
        input logic [31:0] base,
        input logic [31:0] setup,
        input logic rev
    );
        if (addr == DXW_OFS_BASE) begin
            dxw_read = base;
        end else if (addr == DXW_OFS_SETUP) begin
            dxw_read = setup;
        end else if (addr == DXW_OFS_CAP) begin
            dxw_read = dxw_cap_word(rev);
        end else begin
            dxw_read = 32'h0000_0000;
        end
    endfunction

    assign addr_phase = hsel && htrans[1] && hready;
    assign wmask = dxw_wmask(q.setup);

    always_comb begin
        d = q;
        if (ce) begin
            d.sync_a = reverse_strap;
            d.sync_b = q.sync_a;

            // The strap is caught once, after the synchroniser has settled past reset.
            if (q.strap_cnt != DXW_STRAP_WAIT) begin
                d.strap_cnt = q.strap_cnt + 2'h1;
            end
            if (q.strap_cnt == DXW_STRAP_WAIT - 2'h1) begin
                d.reverse = q.sync_b;
            end

            d.ready = 1'b1;

            // Write data phase; software can only reach the base, the setup is read-only here.
            if (q.wr_pend && q.wr_addr == DXW_OFS_BASE) begin
                // Bits with a zero size-mask bit keep their value.
                d.base = (hwdata & wmask) | (q.base & ~wmask);
            end

            // The setup comes in from the side loader; fixed fields are forced.
            if (side_load_valid) begin
                d.setup = side_load_data & DXW_SETUP_KEEP;
            end

            d.wr_pend = 1'b0;
            if (addr_phase) begin
                d.wr_pend = hwrite;
                d.wr_addr = haddr;
                // Read through d so that a read right after a write sees the new value.
                if (!hwrite) begin
                    d.rdata = dxw_read(haddr, d.base, d.setup, q.reverse);
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
            q.ready <= 1'b1;
            q.base <= DXW_BASE_RST;
            q.setup <= DXW_SETUP_RST;
        end else begin
            q <= d;
        end
    end

    assign hrdata = q.rdata;
    assign hreadyout = q.ready;
    assign hresp = 1'b0;
    assign win_enable = q.setup[DXW_SETUP_EN_BIT];
    assign reverse_mode = q.reverse;

    // The translation stage reads the window only through the setup-derived mask.
    dxw_xlate u_xlate (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .win_en(q.setup[DXW_SETUP_EN_BIT]),
        .win_base(q.base),
        .win_mask(wmask),
        .in_valid(dn_valid),
        .in_hit(dn_hit),
        .in_addr(dn_addr),
        .out_valid(xl_valid),
        .out_translated(xl_translated),
        .out_addr(xl_addr)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_rd_cap;
        ce && addr_phase && !hwrite && haddr == DXW_OFS_CAP;
    endsequence

    sequence s_wr_base;
        ce && q.wr_pend && q.wr_addr == DXW_OFS_BASE;
    endsequence

    AST_BASE_LOW_ZERO: assert property (q.base[DXW_BASE_LSB-1:0] == 6'h00)
        else $error("translated base low bits are not zero");

    AST_BASE_WRITE: assert property (s_wr_base |=>
        q.base == (($past(hwdata) & $past(wmask)) | ($past(q.base) & ~$past(wmask))))
        else $error("base write ignored the size mask");

    AST_BASE_MASKED_HOLD: assert property (s_wr_base |=>
        ((q.base ^ $past(q.base)) & ~$past(wmask)) == 32'h0000_0000)
        else $error("read-only base bit changed");

    AST_BASE_ONLY_BY_WRITE: assert property (!s_wr_base |=> $stable(q.base))
        else $error("base changed without a write");

    AST_BASE_READBACK: assert property (s_wr_base ##0 (addr_phase && !hwrite && haddr == DXW_OFS_BASE)
        |=> hrdata == q.base)
        else $error("base readback is stale");

    AST_TYPE_SEL_ZERO: assert property (q.setup[DXW_SETUP_TYPE_BIT] == 1'b0)
        else $error("type selector is not memory");

    AST_ATYPE_RESET: assert property ($fell(srst) |->
        q.setup[DXW_SETUP_ATYPE_MSB:DXW_SETUP_ATYPE_LSB] == DXW_ATYPE_32)
        else $error("address type not 32-bit after reset");

    AST_ENABLE_RESET: assert property ($fell(srst) |-> !win_enable && !xl_translated)
        else $error("window enabled after reset");

    AST_CAP_ID: assert property (s_rd_cap |=> hrdata[7:0] == DXW_CAP_ID)
        else $error("wrong capability identifier");

    AST_CAP_NEXT: assert property (s_rd_cap |=> hrdata[15:8] == DXW_CAP_NEXT)
        else $error("wrong next capability link");

    AST_CAP_TYPE_KNOWN: assert property (s_rd_cap |=> dxw_port_type_known(hrdata[23:20]))
        else $error("reserved device type reported");

    // The read data carries the direction held when the address phase was taken.
    AST_CAP_TYPE_MODE: assert property (s_rd_cap |=>
        hrdata[23:20] == ($past(reverse_mode) ? DXW_PT_PCI_TO_EXP : DXW_PT_EXP_TO_PCI))
        else $error("device type disagrees with direction");

    AST_CAP_SLOT: assert property (s_rd_cap |=> hrdata[24] == $past(reverse_mode))
        else $error("slot flag disagrees with direction");

    AST_SIDE_LOAD: assert property (ce && side_load_valid |=>
        q.setup == ($past(side_load_data) & DXW_SETUP_KEEP))
        else $error("setup not loaded from side port");

    AST_ZERO_WAIT: assert property (hreadyout && !hresp)
        else $error("slave stalled or errored");

    // Setup register contents.
    AST_SETUP_ONLY_BY_LOAD: assert property (!(ce && side_load_valid) |=>
        $stable(q.setup))
        else $error("setup changed without a side load");

    AST_LOAD_ENABLE: assert property (ce && side_load_valid |=>
        win_enable == $past(side_load_data[DXW_SETUP_EN_BIT]))
        else $error("window enable does not follow the loaded value");

    AST_LOAD_ATYPE: assert property (ce && side_load_valid |=>
        q.setup[DXW_SETUP_ATYPE_MSB:DXW_SETUP_ATYPE_LSB] == $past(side_load_data[2:1]))
        else $error("address type does not follow the loaded value");

    AST_SETUP_RSVD_ZERO: assert property (
        q.setup[5:4] == 2'h0)
        else $error("reserved setup bits are not zero");

    // Direction capture; a strap that moved later must not flip the reported type.
    AST_REVERSE_CAPTURE: assert property (ce && q.strap_cnt == DXW_STRAP_WAIT - 2'h1 |=>
        reverse_mode == $past(q.sync_b))
        else $error("direction not taken from the synchronised strap");

    AST_REVERSE_HELD: assert property (q.strap_cnt == DXW_STRAP_WAIT |=>
        $stable(reverse_mode))
        else $error("direction changed after capture");

    AST_STRAP_CNT_STOP: assert property (q.strap_cnt == DXW_STRAP_WAIT |=>
        q.strap_cnt == DXW_STRAP_WAIT)
        else $error("strap counter left its final value");

    AST_STRAP_BEFORE: assert property (q.strap_cnt != DXW_STRAP_WAIT |->
        !reverse_mode)
        else $error("reverse reported before the strap was captured");

    // Register reads on the bus.
    AST_RD_BASE: assert property (ce && addr_phase && !hwrite && haddr == DXW_OFS_BASE &&
        !(q.wr_pend && q.wr_addr == DXW_OFS_BASE) |=> hrdata == $past(q.base))
        else $error("base read returned a wrong value");

    AST_RD_SETUP: assert property (ce && addr_phase && !hwrite && haddr == DXW_OFS_SETUP &&
        !side_load_valid |=> hrdata == $past(q.setup))
        else $error("setup read returned a wrong value");

    AST_RD_UNMAPPED: assert property (ce && addr_phase && !hwrite && haddr != DXW_OFS_BASE &&
        haddr != DXW_OFS_SETUP && haddr != DXW_OFS_CAP |=> hrdata == 32'h0000_0000)
        else $error("unmapped read is not zero");

    AST_CAP_VERSION: assert property (s_rd_cap |=>
        hrdata[19:16] == DXW_CAP_VER)
        else $error("wrong capability version");

    AST_CAP_UPPER_ZERO: assert property (s_rd_cap |=>
        hrdata[31:25] == 7'h00)
        else $error("capability upper bits are not zero");

    AST_RDATA_HOLD: assert property (!(ce && addr_phase && !hwrite) |=>
        $stable(hrdata))
        else $error("read data changed without a read");

    AST_BASE_BIT31: assert property (s_wr_base |=>
        q.base[31] == $past(hwdata[31]))
        else $error("base bit 31 did not take the written value");

    // Clock enable and the translation port.
    AST_CE_FREEZE: assert property (!ce |=>
        $stable(q) && $stable(xl_valid) && $stable(xl_translated) && $stable(xl_addr))
        else $error("state moved while the clock enable was low");

    AST_XL_FOLLOWS: assert property (ce |=>
        xl_valid == $past(dn_valid))
        else $error("translated valid does not follow the request");

    AST_XL_MISS: assert property (ce && dn_valid && !dn_hit |=>
        !xl_translated && xl_addr == $past(dn_addr))
        else $error("missed address was altered");

    AST_XL_NEEDS_ENABLE: assert property ($past(ce) && xl_translated |->
        $past(win_enable))
        else $error("translation with the window disabled");

    AST_XL_NEEDS_HIT: assert property ($past(ce) && xl_translated |->
        $past(dn_valid) && $past(dn_hit))
        else $error("translation without a hit");

    COV_BASE_WRITE: cover property (s_wr_base);
    COV_CAP_READ: cover property (s_rd_cap ##1 reverse_mode);
    COV_SIDE_LOAD_ENABLE: cover property (ce && side_load_valid && side_load_data[DXW_SETUP_EN_BIT]);
    COV_WRITE_THEN_READ: cover property (s_wr_base ##0 (addr_phase && !hwrite));

endmodule

// ### dv/dxw_far_agent.sv
module dxw_far_agent (
    // Clock.
    input wire logic ref_clk,
    // Setup side loading.
    output logic side_load_valid,
    output logic [31:0] side_load_data,
    // Downstream requests.
    output logic dn_valid,
    output logic dn_hit,
    output logic [31:0] dn_addr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        side_load_valid = 1'b0;
        side_load_data = 32'h0000_0000;
        dn_valid = 1'b0;
        dn_hit = 1'b0;
        dn_addr = 32'h0000_0000;
    end

    // Memory windows must keep mask bits 11:6 clear, so they are cleared whatever the caller asks.
    task automatic load(input logic [31:0] d);
        @(posedge ref_clk);
        side_load_valid <= 1'b1;
        side_load_data <= d & 32'hffff_f03f;
        @(posedge ref_clk);
        side_load_valid <= 1'b0;
        side_load_data <= ~(d & 32'hffff_f03f);
    endtask

    // Each call makes one request and releases the lines at the edge that takes it.
    task automatic send(input logic h, input logic [31:0] a);
        @(posedge ref_clk);
        dn_valid <= 1'b1;
        dn_hit <= h;
        dn_addr <= a;
        @(posedge ref_clk);
        idle();
    endtask

    // Released hit and address lines toggle and valid drops low, so stale values are never mistaken for live ones.
    task automatic idle();
        dn_valid <= 1'b0;
        dn_hit <= ~dn_hit;
        dn_addr <= ~dn_addr;
    endtask
endmodule

// ### dv/downstream_xlate_window_and_pcie_cap_tb_top.sv
module downstream_xlate_window_and_pcie_cap_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dxw_pkg::*;

    logic ref_clk, srst, ce, hsel, hwrite, hready, hreadyout, hresp, reverse_strap;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, side_load_data, dn_addr, xl_addr, rd;
    logic side_load_valid, dn_valid, dn_hit, xl_valid, xl_translated, win_enable, reverse_mode;
    int err_total = 0;
    int samples_checked = 0;

    assign hready = hreadyout;

    dxw_regs u_dut (.ref_clk(ref_clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .reverse_strap(reverse_strap),
        .side_load_valid(side_load_valid), .side_load_data(side_load_data), .dn_valid(dn_valid),
        .dn_hit(dn_hit), .dn_addr(dn_addr), .xl_valid(xl_valid), .xl_translated(xl_translated),
        .xl_addr(xl_addr), .win_enable(win_enable), .reverse_mode(reverse_mode));

    dxw_far_agent u_far (.ref_clk(ref_clk), .side_load_valid(side_load_valid),
        .side_load_data(side_load_data), .dn_valid(dn_valid), .dn_hit(dn_hit), .dn_addr(dn_addr));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One single AHB-Lite transfer; entered just after a rising edge.
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    // The strap must be steady from release on, so it is set together with reset.
    task automatic do_reset(input logic r);
        @(posedge ref_clk);
        reverse_strap <= r;
        srst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask

    task automatic test_after_reset(input logic r);
        ahb(DXW_OFS_BASE, 1'b0, 32'h0000_0000, rd);
        chk("base reset", rd, 32'h0000_0000);
        ahb(DXW_OFS_SETUP, 1'b0, 32'h0000_0000, rd);
        chk("setup reset", rd, 32'h0000_0000);
        chk("win_enable reset", {31'h0, win_enable}, 32'h0000_0000);
        ahb(DXW_OFS_CAP, 1'b0, 32'h0000_0000, rd);
        chk("cap id", {24'h0, rd[7:0]}, 32'h0000_0010);
        chk("cap next", {24'h0, rd[15:8]}, 32'h0000_00f0);
        chk("port type", {28'h0, rd[23:20]}, r ? 32'h0000_0008 : 32'h0000_0007);
        chk("slot", {31'h0, rd[24]}, {31'h0, r});
        chk("cap word", rd, r ? 32'h0181_f010 : 32'h0071_f010);
        chk("reverse_mode", {31'h0, reverse_mode}, {31'h0, r});
    endtask

    task automatic test_mask();
        ahb(DXW_OFS_BASE, 1'b1, 32'hffff_ffff, rd);
        ahb(DXW_OFS_BASE, 1'b0, 32'h0000_0000, rd);
        chk("base mask zero", rd, 32'h8000_0000);
        @(posedge ref_clk);
        u_far.load(32'h8000_f00b);
        ahb(DXW_OFS_SETUP, 1'b1, 32'h0000_0000, rd);
        ahb(DXW_OFS_SETUP, 1'b0, 32'h0000_0000, rd);
        chk("setup loaded", rd, 32'h8000_f00a);
        chk("address type", {30'h0, rd[2:1]}, 32'h0000_0001);
        chk("win_enable set", {31'h0, win_enable}, 32'h0000_0001);
        ahb(DXW_OFS_BASE, 1'b1, 32'h0000_503f, rd);
        ahb(DXW_OFS_BASE, 1'b0, 32'h0000_0000, rd);
        chk("base masked write", rd, 32'h0000_5000);
        ahb(8'h40, 1'b0, 32'h0000_0000, rd);
        chk("unmapped", rd, 32'h0000_0000);
    endtask

    // The translated request stands for one cycle, so it is looked at mid-cycle.
    task automatic xchk(input logic v, input logic t, input logic [31:0] a);
        @(negedge ref_clk);
        chk("xl flags", {30'h0, xl_valid, xl_translated}, {30'h0, v, t});
        chk("xl addr", xl_addr, a);
    endtask

    task automatic test_xlate();
        u_far.send(1'b1, 32'h9234_abcd);
        xchk(1'b1, 1'b1, 32'h1234_5bcd);
        u_far.send(1'b0, 32'h9234_abcd);
        xchk(1'b1, 1'b0, 32'h9234_abcd);
        u_far.send(1'b1, 32'h0000_0fff);
        xchk(1'b1, 1'b1, 32'h0000_5fff);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("xl_valid idle", {31'h0, xl_valid}, 32'h0000_0000);
        u_far.load(32'h0000_f00a);
        u_far.send(1'b1, 32'h9234_abcd);
        xchk(1'b1, 1'b0, 32'h9234_abcd);
        // With the clock enable low neither a load nor a request may land.
        @(posedge ref_clk);
        ce <= 1'b0;
        u_far.load(32'h8000_f00a);
        u_far.send(1'b1, 32'h9234_abcd);
        @(negedge ref_clk);
        chk("frozen enable", {31'h0, win_enable}, 32'h0000_0000);
        chk("frozen request", {31'h0, xl_valid}, 32'h0000_0000);
        @(posedge ref_clk);
        ce <= 1'b1;
    endtask

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        reverse_strap = 1'b0;
        do_reset(1'b0);
        test_after_reset(1'b0);
        test_mask();
        test_xlate();
        do_reset(1'b1);
        test_after_reset(1'b1);
        final_report();
    end

    // The whole sequence needs under a hundred cycles; this bound only catches a hung bus.
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        final_report();
    end
endmodule
